// file: verilog/bdf_framer.sv
// Digit scan to byte word framer with measurement request control
// Summary of operation
// R1: Each digit strobe launches one word, five per reading
// R2: Byte is digit tag high, BCD nibble low
// R3: Polarity drives transmitter even parity select
// R4: Receive parity error means positive, else negative
// R5: Received word requests a new measurement
// R6: Busy from converter clears receiver ready flag
// R7: Top digit word carries polarity and range flags
// R8: Word must be sent before next strobe
// R9: Parity held constant over one five word stream
// R10: Wide host reads all fields in one word
// R11: Narrow host gets flags folded into top word
// R12: Host can command start and hold
// R13: Short mode: mode select low, slower clock
// R14: Top digit select feeds decoder ripple blanking
// R15: Converter scans top digit down to lowest
// R16: BCD changes together with its digit select
// R17: Selects blanked on over-range until integration; the converter model still scans all five selects on over-range
// R18: Sample select, nibble, flags on strobe edge
// R19: Tag is one-hot of select, top is zero
//
// The address map and the address-and-strobe port were decided locally.
`include "bdf_regs.svh"
module bdf_framer
  import bdf_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Software register port
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output logic irq,
  // Converter pins
  input wire logic [4:0] digit_select,
  input wire logic [3:0] bcd_digit,
  input wire logic conv_strobe,
  input wire logic conv_busy,
  input wire logic conv_polarity,
  input wire logic conv_over_range,
  input wire logic conv_under_range,
  output logic conv_run,
  output logic digit_mode_select,
  // Display decoder
  output logic ripple_blank_in,
  // UART transmit side
  input wire logic tx_ready,
  output logic [7:0] tx_word,
  output logic tx_load,
  output logic even_parity_select,
  // UART receive side
  input wire logic uart_receive_input,
  input wire logic rx_parity_error,
  output logic rx_ready_clear
);
  // Pin synchronisers, one pair per bit
  bdf_pins_t pins;
  logic [`BDF_PIN_W-1:0] sync1_q;
  logic [`BDF_PIN_W-1:0] sync2_q;
  bdf_pins_t s;
  assign pins = '{conv_strobe, conv_busy, conv_polarity, conv_over_range,
                  conv_under_range, bcd_digit, digit_select};
  genvar gi;
  generate
    for (gi = 0; gi < `BDF_PIN_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pins[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  assign s = bdf_pins_t'(sync2_q);

  // Main state
  logic strb_prev_q, busy_prev_q, rxr_prev_q;
  bdf_hold_t hold_q, hold_d;
  logic [7:0] word_q, word_d;
  logic [2:0] cnt_q, cnt_d;
  logic stream_q, stream_d;
  logic [3:0] ctrl_q, ctrl_d;
  logic [`BDF_ST_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic [11:0] pword_q, pword_d;
  logic [7:0] bword_q, bword_d;
  logic rsign_q, rsign_d;
  logic req_q, req_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic run_q, run_d;
  logic rbi_q, rbi_d;
  logic [7:0] txw_q, txw_d;
  logic txl_q, txl_d;
  logic par_q, par_d;
  logic drr_q, drr_d;
  logic strb_rise, busy_rise, rx_rise, top, wr_ctrl, rd_stat;
  logic [3:0] nib;
  logic [`BDF_ST_W-1:0] ev;

  always_comb begin
    strb_rise = s.strobe && !strb_prev_q;
    busy_rise = s.busy && !busy_prev_q;
    rx_rise = uart_receive_input && !rxr_prev_q;
    top = s.dsel[`BDF_TOP];
    wr_ctrl = bus_wr && (bus_addr == `BDF_OFF_CTRL);
    rd_stat = bus_rd && (bus_addr == `BDF_OFF_STAT);
    hold_d = hold_q;
    word_d = word_q;
    cnt_d = cnt_q;
    stream_d = stream_q;
    pword_d = pword_q;
    bword_d = bword_q;
    txw_d = txw_q;
    txl_d = 1'b0;
    par_d = par_q;
    ev = '0;
    // Flags fold onto the unused upper weights of the top digit
    nib = s.bcd;
    if (top && ctrl_q[`BDF_CTRL_MUX]) begin
      nib = {s.polarity, s.over_range, s.under_range, s.bcd[0]}; // [R7] [R11]
    end
    // Hand the held word to the transmitter when it is free
    if (hold_q == BDF_FULL && tx_ready) begin
      txw_d = word_q;
      txl_d = 1'b1;
      hold_d = BDF_EMPTY;
      ev[`BDF_ST_WORD] = 1'b1;
    end
    // Blanked scans carry no digit and send nothing
    if (strb_rise && s.dsel != 5'h00) begin
      word_d = {s.dsel[3:0], nib}; // [R2] [R18] [R19]
      pword_d = {s.polarity, s.over_range, s.under_range,
                 s.bcd, s.dsel}; // [R10] [R16]
      bword_d = word_d;
      if (hold_d == BDF_FULL) begin
        ev[`BDF_ST_OVR] = 1'b1; // [R8]
      end
      hold_d = BDF_FULL; // [R1]
      if (top) begin
        // Sign latched once per stream
        par_d = s.polarity; // [R3] [R9]
        cnt_d = `BDF_CNT_ONE;
        stream_d = 1'b1;
      end else if (stream_q) begin
        cnt_d = cnt_q + `BDF_CNT_ONE;
      end
      if (stream_q && cnt_d == `BDF_WORDS) begin
        ev[`BDF_ST_READ] = 1'b1; // [R1]
        stream_d = 1'b0;
      end
    end
    if (rx_rise) begin
      ev[`BDF_ST_REQ] = 1'b1;
    end
  end

  // Registers, requests and interrupt
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    rsign_d = rsign_q;
    req_d = req_q;
    if (wr_ctrl) begin
      ctrl_d = bus_wdata[3:0];
      ctrl_d[`BDF_CTRL_START] = 1'b0;
    end
    if (bus_wr && bus_addr == `BDF_OFF_MASK) begin
      mask_d = bus_wdata[`BDF_ST_W-1:0];
    end
    // Busy consumes a pending request; a new one in that cycle survives
    if (busy_rise) begin
      req_d = 1'b0;
    end
    if (rx_rise || (wr_ctrl && bus_wdata[`BDF_CTRL_START])) begin
      req_d = 1'b1; // [R5] [R12]
    end
    if (rx_rise) begin
      // Receiver runs with odd parity, so an error means even: positive
      rsign_d = rx_parity_error; // [R4]
    end
    // Set wins over read clear
    stat_d = (rd_stat ? '0 : stat_q) | ev;
    irq_d = |(stat_d & mask_d);
    run_d = ctrl_d[`BDF_CTRL_RUN] || req_d; // [R12]
    drr_d = busy_rise; // [R6]
    rbi_d = top; // [R14]
    rdata_d = `BDF_ZERO32;
    if (bus_rd) begin
      unique case (bus_addr)
        `BDF_OFF_CTRL: rdata_d[3:0] = ctrl_q;
        `BDF_OFF_STAT: rdata_d[`BDF_ST_W-1:0] = stat_q;
        `BDF_OFF_MASK: rdata_d[`BDF_ST_W-1:0] = mask_q;
        `BDF_OFF_PWORD: rdata_d[11:0] = pword_q;
        `BDF_OFF_BWORD: rdata_d[7:0] = bword_q;
        `BDF_OFF_RSIGN: rdata_d[0] = rsign_q;
        default: rdata_d = `BDF_ZERO32;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strb_prev_q <= 1'b0;
      busy_prev_q <= 1'b0;
      rxr_prev_q <= 1'b0;
      hold_q <= BDF_EMPTY;
      word_q <= 8'h00;
      cnt_q <= 3'h0;
      stream_q <= 1'b0;
      ctrl_q <= `BDF_CTRL_RST;
      stat_q <= '0;
      mask_q <= '0;
      pword_q <= 12'h000;
      bword_q <= 8'h00;
      rsign_q <= 1'b0;
      req_q <= 1'b0;
      rdata_q <= `BDF_ZERO32;
      irq_q <= 1'b0;
      run_q <= 1'b0;
      rbi_q <= 1'b0;
      txw_q <= 8'h00;
      txl_q <= 1'b0;
      par_q <= 1'b0;
      drr_q <= 1'b0;
    end else begin
      strb_prev_q <= s.strobe;
      busy_prev_q <= s.busy;
      rxr_prev_q <= uart_receive_input;
      hold_q <= hold_d;
      word_q <= word_d;
      cnt_q <= cnt_d;
      stream_q <= stream_d;
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      pword_q <= pword_d;
      bword_q <= bword_d;
      rsign_q <= rsign_d;
      req_q <= req_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      run_q <= run_d;
      rbi_q <= rbi_d;
      txw_q <= txw_d;
      txl_q <= txl_d;
      par_q <= par_d;
      drr_q <= drr_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign irq = irq_q;
  assign conv_run = run_q;
  assign digit_mode_select = ctrl_q[`BDF_CTRL_MODE]; // [R13]
  assign ripple_blank_in = rbi_q;
  assign tx_word = txw_q;
  assign tx_load = txl_q;
  assign even_parity_select = par_q;
  assign rx_ready_clear = drr_q;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_top_strobe;
    strb_rise && top;
  endsequence
  sequence s_drr_pulse;
    rx_ready_clear ##1 !rx_ready_clear;
  endsequence

  property p_top_tag;
    s_top_strobe |=> word_q[7:4] == 4'h0 ##0 hold_q == BDF_FULL;
  endproperty
  a_top_tag: assert property (p_top_tag) else $error("top tag wrong"); // [R19]

  property p_d4_tag;
    strb_rise && s.dsel == 5'h08 |=> word_q == {4'h8, $past(s.bcd)};
  endproperty
  a_d4_tag: assert property (p_d4_tag) else $error("d4 word wrong"); // [R2]

  property p_mux;
    s_top_strobe and ctrl_q[`BDF_CTRL_MUX] |=>
      word_q[3:1] == {$past(s.polarity), $past(s.over_range),
                      $past(s.under_range)};
  endproperty
  a_mux: assert property (p_mux) else $error("flags not folded"); // [R7]

  property p_load;
    hold_q == BDF_FULL && tx_ready && !strb_rise |=>
      tx_load && tx_word == $past(word_q) ##1 !tx_load;
  endproperty
  a_load: assert property (p_load) else $error("word not loaded"); // [R1]

  property p_par_hold;
    stream_q && !strb_rise |=> $stable(even_parity_select);
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("parity moved"); // [R9]

  property p_drr;
    busy_rise |=> s_drr_pulse;
  endproperty
  a_drr: assert property (p_drr) else $error("ready not cleared"); // [R6]

  property p_req;
    rx_rise |=> ##1 conv_run;
  endproperty
  a_req: assert property (p_req) else $error("request lost"); // [R5]

  property p_ovr;
    strb_rise && s.dsel != 5'h00 && hold_q == BDF_FULL && !tx_ready |=>
      stat_q[`BDF_ST_OVR] ##1 irq == mask_q[`BDF_ST_OVR] || irq;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun missed"); // [R8]

  property p_sign;
    rx_rise |=> rsign_q == $past(rx_parity_error);
  endproperty
  a_sign: assert property (p_sign) else $error("sign wrong"); // [R4]

  property p_rbi;
    1'b1 |=> ripple_blank_in == $past(top);
  endproperty
  a_rbi: assert property (p_rbi) else $error("blank input wrong"); // [R14]

  property p_pword;
    strb_rise && s.dsel != 5'h00 |=>
      pword_q == {$past(s.polarity), $past(s.over_range),
                  $past(s.under_range), $past(s.bcd), $past(s.dsel)};
  endproperty
  a_pword: assert property (p_pword) else $error("wide word wrong"); // [R10]

  // Interrupt only from an unmasked sticky bit
  property p_irq;
    irq |-> |(stat_q & mask_q);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule

// file: pkg/bdf_regs.svh
// Register offsets, field positions and constants of the digit framer
`ifndef BDF_REGS_SVH
`define BDF_REGS_SVH
`define BDF_OFF_CTRL 8'h00
`define BDF_OFF_STAT 8'h04
`define BDF_OFF_MASK 8'h08
`define BDF_OFF_PWORD 8'h0c
`define BDF_OFF_BWORD 8'h10
`define BDF_OFF_RSIGN 8'h14
`define BDF_CTRL_RUN 0
`define BDF_CTRL_START 1
`define BDF_CTRL_MUX 2
`define BDF_CTRL_MODE 3
`define BDF_CTRL_RST 4'h5
`define BDF_ST_WORD 0
`define BDF_ST_READ 1
`define BDF_ST_OVR 2
`define BDF_ST_REQ 3
`define BDF_ST_W 4
`define BDF_TOP 4
`define BDF_WORDS 3'h5
`define BDF_CNT_ONE 3'h1
`define BDF_PIN_W 14
`define BDF_ZERO32 32'h0000_0000
`endif

// file: pkg/bdf_pkg.sv
// Types shared by the digit framer
package bdf_pkg;
  typedef struct packed {
    logic strobe;
    logic busy;
    logic polarity;
    logic over_range;
    logic under_range;
    logic [3:0] bcd;
    logic [4:0] dsel;
  } bdf_pins_t;

  typedef struct packed {
    logic polarity;
    logic over_range;
    logic under_range;
    logic [3:0] bcd;
    logic [4:0] dsel;
  } bdf_pword_t;

  typedef enum logic {
    BDF_EMPTY = 1'b0,
    BDF_FULL = 1'b1
  } bdf_hold_t;
endpackage

// file: tb/bdf_conv_model.sv
// Behavioural converter: busy phase, then a top-to-low digit scan
module bdf_conv_model #(
  parameter int DIG_CYC = 24
) (
  // Clock and run request
  input wire logic ref_clk,
  input wire logic conv_run,
  // Reading supplied by the bench
  input wire logic [19:0] reading,
  input wire logic sign,
  input wire logic ovr,
  // Converter outputs
  output logic [4:0] digit_select,
  output logic [3:0] bcd_digit,
  output logic conv_strobe,
  output logic conv_busy,
  output logic conv_polarity,
  output logic conv_over_range,
  output logic conv_under_range
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {digit_select, bcd_digit, conv_strobe, conv_busy} = '0;
    {conv_polarity, conv_over_range, conv_under_range} = '0;
    forever begin
      @(posedge ref_clk);
      if (conv_run === 1'b1) begin
        conv_busy <= 1'b1;
        repeat (6) @(posedge ref_clk);
        conv_busy <= 1'b0;
        // Sign fixed for the whole stream
        conv_polarity <= sign;
        conv_over_range <= ovr;
        conv_under_range <= !ovr;
        for (int k = 4; k >= 0; k--) begin
          digit_select <= 5'(1 << k);
          bcd_digit <= reading[4*k +: 4];
          for (int c = 0; c < DIG_CYC; c++) begin
            conv_strobe <= (c >= 8 && c < 12);
            @(posedge ref_clk);
          end
        end
        // Blank between scans; stale nibble toggles so it is never reused
        digit_select <= 5'h00;
        bcd_digit <= ~bcd_digit;
        repeat (10) @(posedge ref_clk);
      end
    end
  end
endmodule

// file: tb/tb_bdf_framer.sv
// Self-checking bench for the digit framer with a converter model
`include "bdf_regs.svh"
module tb_bdf_framer;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk, rst_n, bus_wr, bus_rd, tx_ready, uart_receive_input;
  logic rx_parity_error, irq, conv_run, digit_mode_select, ripple_blank_in;
  logic tx_load, even_parity_select, rx_ready_clear, sign, ovr;
  logic conv_strobe, conv_busy, conv_polarity, conv_over_range;
  logic conv_under_range;
  logic [7:0] bus_addr, tx_word;
  logic [31:0] bus_wdata, bus_rdata, rd_val;
  logic [19:0] reading;
  logic [4:0] digit_select;
  logic [3:0] bcd_digit;
  logic [7:0] words[$];
  int num_errors, check_count, clr_count, rbi_count;

  bdf_framer bdf_framer_i (.ref_clk, .rst_n, .bus_addr, .bus_wdata,
    .bus_wr, .bus_rd, .bus_rdata, .irq, .digit_select, .bcd_digit,
    .conv_strobe, .conv_busy, .conv_polarity, .conv_over_range,
    .conv_under_range, .conv_run, .digit_mode_select, .ripple_blank_in,
    .tx_ready, .tx_word, .tx_load, .even_parity_select,
    .uart_receive_input, .rx_parity_error, .rx_ready_clear);

  bdf_conv_model bdf_conv_model_i (.ref_clk, .conv_run, .reading, .sign,
    .ovr, .digit_select, .bcd_digit, .conv_strobe, .conv_busy,
    .conv_polarity, .conv_over_range, .conv_under_range);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Receiver side: ready flag stays up until the framer clears it
  always @(posedge ref_clk) begin
    if (tx_load === 1'b1) words.push_back(tx_word);
    if (rx_ready_clear === 1'b1) begin
      clr_count++;
      uart_receive_input <= 1'b0;
    end
    if (ripple_blank_in === 1'b1 && digit_select[4] === 1'b1) rbi_count++;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // A gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 rd_val = bus_rdata;
    chk(nm, e, rd_val);
    @(posedge ref_clk);
  endtask

  task automatic wait_words(input int n);
    int t;
    t = 0;
    while (words.size() < n && t < 2000) begin
      @(posedge ref_clk);
      t++;
    end
    chk("word count", 32'(n), 32'(words.size()));
  endtask

  task automatic chk_stream(input logic mux, input logic p);
    logic [4:0] sel;
    logic [3:0] nib;
    for (int k = 4; k >= 0; k--) begin
      sel = 5'(1 << k);
      nib = reading[4*k +: 4];
      if (k == 4 && mux) nib = {p, ovr, !ovr, nib[0]};
      chk("tx word", {24'h0, sel[3:0], nib}, {24'h0, words.pop_front()});
    end
  endtask

  initial begin
    #50000;
    num_errors++;
    stop_test();
  end

  initial begin
    {rst_n, bus_wr, bus_rd, uart_receive_input, rx_parity_error} = '0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    tx_ready = 1'b1;
    sign = 1'b1;
    ovr = 1'b1;
    reading = 20'h12975;
    {num_errors, check_count, clr_count, rbi_count} = '0;
    repeat (4) @(posedge ref_clk);
    chk("mode rst", 32'h0, 32'(digit_mode_select));
    chk("run rst", 32'h0, 32'(conv_run));
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdchk(`BDF_OFF_MASK, 32'h0, "mask rst");
    wr(8'h40, 32'hffff_ffff);
    rdchk(8'h40, 32'h0, "unmapped");
    wr(`BDF_OFF_MASK, 32'h2);
    chk("run", 32'h1, 32'(conv_run));
    wait_words(5);
    wr(`BDF_OFF_CTRL, 32'h0c);
    chk_stream(1'b1, 1'b1);
    chk("parity", 32'h1, 32'(even_parity_select));
    chk("blank", 32'h1, 32'(rbi_count > 0));
    chk("irq", 32'h1, 32'(irq));
    chk("rx clear boot", 32'h1, 32'(clr_count));
    rdchk(`BDF_OFF_BWORD, 32'h15, "bword");
    rdchk(`BDF_OFF_PWORD, 32'hca1, "pword");
    rdchk(`BDF_OFF_STAT, 32'h3, "stat");
    rdchk(`BDF_OFF_STAT, 32'h0, "stat clr");
    chk("irq clr", 32'h0, 32'(irq));
    repeat (200) @(posedge ref_clk);
    chk("held", 32'h0, 32'(words.size()));
    sign <= 1'b0;
    rx_parity_error <= 1'b1;
    uart_receive_input <= 1'b1;
    wait_words(5);
    chk_stream(1'b1, 1'b0);
    chk("parity neg", 32'h0, 32'(even_parity_select));
    chk("rx clear", 32'h2, 32'(clr_count));
    rdchk(`BDF_OFF_RSIGN, 32'h1, "rsign");
    rdchk(`BDF_OFF_STAT, 32'hb, "stat req");
    repeat (200) @(posedge ref_clk);
    chk("one req", 32'h0, 32'(words.size()));
    wr(`BDF_OFF_MASK, 32'h0);
    wr(`BDF_OFF_CTRL, 32'h02);
    chk("mode short", 32'h0, 32'(digit_mode_select));
    wait_words(5);
    chk_stream(1'b0, 1'b0);
    repeat (3) @(posedge ref_clk);
    chk("masked", 32'h0, 32'(irq));
    wr(`BDF_OFF_MASK, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk("unmasked", 32'h1, 32'(irq));
    rdchk(`BDF_OFF_STAT, 32'h3, "stat short");
    // Transmitter stalled: every strobe after the first overruns the held word
    tx_ready <= 1'b0;
    ovr <= 1'b0;
    wr(`BDF_OFF_MASK, 32'h4);
    wr(`BDF_OFF_CTRL, 32'h02);
    repeat (160) @(posedge ref_clk);
    chk("no load", 32'h0, 32'(words.size()));
    chk("irq ovr", 32'h1, 32'(irq));
    rdchk(`BDF_OFF_STAT, 32'h6, "stat ovr");
    rdchk(`BDF_OFF_PWORD, 32'h2a1, "pword udr");
    tx_ready <= 1'b1;
    wait_words(1);
    chk("late word", 32'h15, {24'h0, words.pop_front()});
    stop_test();
  end
endmodule
